// [dcc_regs.svh]
// Register offsets, field positions, reset values and counts for the DMA channel control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

`define DCC_NUM_CH 4
// Byte offsets of per-channel control registers, one word each, then interrupt status, interrupt mask and grant
`define DCC_CTRL_BASE 8'h00
`define DCC_IRQ_STAT 8'h10
`define DCC_IRQ_MASK 8'h14
`define DCC_GRANT 8'h18
// Control register fields
`define DCC_ACTIVE_BIT 15
`define DCC_CHAIN_DIR_BIT 8
`define DCC_ON_BIT 7
`define DCC_EVOFF_BIT 6
`define DCC_CHAIN_BIT 5
`define DCC_AUTO_BIT 4
`define DCC_SEEN_BIT 2
`define DCC_PRI_HI 1
`define DCC_PRI_LO 0
// Writable bits of the control register
`define DCC_CTRL_WMASK 32'h0000_01f3
`define DCC_CTRL_RESET 32'h0000_0000
// Interrupt status layout: per channel, block done then event seen
`define DCC_IRQ_DONE_LO 0
`define DCC_IRQ_EVT_LO 4
`define DCC_IRQ_W 8

`endif

// [dcc_pkg.sv]
// Types shared by the DMA channel control block.
// Assumes dcc_regs.svh sits in the same folder.
`include "dcc_regs.svh"

package dcc_pkg;

  // Per-channel software controls
  typedef struct packed {
    logic chain_direction_select;
    logic channel_on;
    logic events_while_off;
    logic chain_allow;
    logic auto_reenable;
    logic [1:0] channel_priority_level;
  } dcc_ctrl_t;

  // Events from the transfer engine for one channel
  typedef struct packed {
    logic start_evt;
    logic abort_evt;
    logic block_done;
    logic bus_busy;
  } dcc_evt_t;

  // Per-channel run state
  typedef enum logic [1:0] {
    DCC_IDLE = 2'b00,
    DCC_RUN = 2'b01,
    DCC_DRAIN = 2'b10
  } dcc_state_t;

endpackage

// [dcc_channel.sv]
// One DMA channel's run state, event capture and enable handling.
// Assumes engine strobes are synchronous to aclk.
`timescale 1ns/1ps

module dcc_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dcc_pkg::dcc_ctrl_t ctrl,
  input wire dcc_pkg::dcc_evt_t evt,
  input wire logic chain_in,
  input wire logic sw_on_write,
  input wire logic sw_on_value,
  input wire logic sw_clear_seen,
  output logic channel_on,
  output logic active,
  output logic event_seen,
  output logic run_req,
  output logic start_taken,
  output logic abort_taken
);

  dcc_pkg::dcc_state_t state_ff, nxt_state;
  logic on_ff, nxt_on;
  logic seen_ff, nxt_seen;
  logic accept;

  assign channel_on = on_ff;
  assign event_seen = seen_ff;
  assign active = (state_ff != dcc_pkg::DCC_IDLE) || on_ff; // RULE1
  assign run_req = (state_ff == dcc_pkg::DCC_RUN) && on_ff && seen_ff;
  // Events count while on, or while off if software allows it
  assign accept = on_ff || ctrl.events_while_off; // RULE5
  assign start_taken = evt.start_evt && accept;
  assign abort_taken = evt.abort_evt && accept;

  ////////////////////////////////////////////////////////////////
  // Next enable, event flag and state
  always_comb begin
    nxt_on = on_ff;
    nxt_seen = seen_ff;
    nxt_state = state_ff;
    if (sw_on_write) begin
      nxt_on = sw_on_value; // RULE4
    end
    if (evt.block_done && on_ff && !ctrl.auto_reenable) begin
      nxt_on = 1'b0; // RULE7
    end
    if (abort_taken) begin
      nxt_on = 1'b0;
    end
    // Chain enable only when allowed; wins over a software write
    if (chain_in && ctrl.chain_allow) begin
      nxt_on = 1'b1; // RULE6
    end
    if (sw_clear_seen || evt.block_done || abort_taken) begin
      nxt_seen = 1'b0;
    end
    // Set wins over clear
    if (start_taken) begin
      nxt_seen = 1'b1; // RULE8
    end
    unique case (state_ff)
      dcc_pkg::DCC_IDLE: begin
        if (on_ff) begin
          nxt_state = dcc_pkg::DCC_RUN;
        end
      end
      dcc_pkg::DCC_RUN: begin
        if (!on_ff) begin
          nxt_state = dcc_pkg::DCC_DRAIN;
        end
      end
      // Hold active until the bus beat in flight completes
      dcc_pkg::DCC_DRAIN: begin
        if (!evt.bus_busy) begin
          nxt_state = dcc_pkg::DCC_IDLE; // RULE10
        end
      end
      default: begin
        nxt_state = dcc_pkg::DCC_IDLE;
      end
    endcase
  end

  // Register the state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= dcc_pkg::DCC_IDLE;
      on_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      on_ff <= nxt_on;
      seen_ff <= nxt_seen;
    end
  end

endmodule

// [dcc_top.sv]
// AXI4-Lite register block and arbiter for four DMA channel controls.
// Assumes the transfer engine drives start, abort, done and busy strobes on aclk.
`timescale 1ns/1ps
`include "dcc_regs.svh"

// Functional notes
// (RULE1) Active flag reads 1 while channel runs or is enabled, else 0.
// (RULE2) Direction 1 chains from lower-priority neighbour's done; 0 from higher one.
// (RULE3) Direction select matters only while chaining is allowed.
// (RULE4) Enable bit 1 means channel enabled; 0 means disabled.
// (RULE5) Events-while-off bit lets start and abort register while disabled.
// (RULE6) Chaining enables the channel only when chain allow is set.
// (RULE7) Without auto re-enable, block completion clears the channel enable.
// (RULE8) Read-only event flag shows whether a start event was detected.
// (RULE9) Two-bit priority field equals priority level, 0 lowest, 3 highest.
// (RULE10) Disabling finishes the bus beat before suspend; active stays set meanwhile.
// (RULE11) Software polls the active flag for 0 before assuming suspension.
// (RULE12) Unimplemented control bits 31-16, 14-9 and 3 read as zero.
// (RULE13) Grant highest priority enabled requester; ties go to lowest number.
module dcc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] eng_start,
  input wire logic [3:0] eng_abort,
  input wire logic [3:0] eng_block_done,
  input wire logic [3:0] eng_bus_busy,
  output logic [3:0] grant_ff,
  output logic [3:0] start_taken_ff,
  output logic [3:0] abort_taken_ff,
  output logic irq_ff
);

  localparam int NCH = `DCC_NUM_CH;

  dcc_pkg::dcc_ctrl_t ctrl_ff [NCH];
  dcc_pkg::dcc_ctrl_t nxt_ctrl [NCH];
  logic [NCH-1:0] ch_on, ch_active, ch_seen, ch_req, ch_start, ch_abort;
  logic [NCH-1:0] chain_in, on_wr, seen_clr;
  logic [`DCC_IRQ_W-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
  logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [7:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [3:0] ws_ff, nxt_ws;
  logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
  logic [3:0] nxt_grant;
  logic do_wr, do_rd;
  logic [7:0] ra;
  logic [31:0] wmerge;
  logic rd_ctrl_hit, wr_ctrl_hit;
  logic [1:0] rd_idx, wr_idx;
  // Readies are flops of their own so that every port leaves a register
  logic awrdy_ff, wrdy_ff, ardy_ff;

  // Bus outputs straight from their registers
  assign s_axi_awready = awrdy_ff;
  assign s_axi_wready = wrdy_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_arready = ardy_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rr_ff;

  assign do_wr = aw_ff && w_ff && !bv_ff;
  assign do_rd = s_axi_arvalid && !rv_ff;
  assign ra = s_axi_araddr;
  assign wr_ctrl_hit = (awa_ff[7:4] == 4'h0) && (awa_ff[1:0] == 2'b00);
  assign rd_ctrl_hit = (ra[7:4] == 4'h0) && (ra[1:0] == 2'b00);
  assign wr_idx = awa_ff[3:2];
  assign rd_idx = ra[3:2];
  assign wmerge = {{8{ws_ff[3]}}, {8{ws_ff[2]}}, {8{ws_ff[1]}}, {8{ws_ff[0]}}} & wd_ff;

  ////////////////////////////////////////////////////////////////
  // Channel instances and chain wiring
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gch
      // Chain source is the neighbour picked by direction, gated by allow
      if (g == 0) begin : glo
        assign chain_in[g] = ctrl_ff[g].chain_allow && ctrl_ff[g].chain_direction_select
          && eng_block_done[g+1]; // RULE2 RULE3
      end else if (g == NCH - 1) begin : ghi
        assign chain_in[g] = ctrl_ff[g].chain_allow && !ctrl_ff[g].chain_direction_select
          && eng_block_done[g-1]; // RULE2 RULE3
      end else begin : gmid
        assign chain_in[g] = ctrl_ff[g].chain_allow && (ctrl_ff[g].chain_direction_select ?
          eng_block_done[g+1] : eng_block_done[g-1]); // RULE2 RULE3
      end
      // Enable bit lives in byte lane 0, so only that lane may write it
      assign on_wr[g] = do_wr && wr_ctrl_hit && (wr_idx == g) && ws_ff[0];
      // Reading the control register consumes the event flag
      assign seen_clr[g] = do_rd && rd_ctrl_hit && (rd_idx == g);
      // One channel's state machine; engine strobes packed into the event struct
      dcc_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctrl(ctrl_ff[g]),
        .evt({eng_start[g], eng_abort[g], eng_block_done[g], eng_bus_busy[g]}),
        .chain_in(chain_in[g]),
        .sw_on_write(on_wr[g]),
        .sw_on_value(wd_ff[`DCC_ON_BIT]),
        .sw_clear_seen(seen_clr[g]),
        .channel_on(ch_on[g]),
        .active(ch_active[g]),
        .event_seen(ch_seen[g]),
        .run_req(ch_req[g]),
        .start_taken(ch_start[g]),
        .abort_taken(ch_abort[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Control fields and interrupt registers
  always_comb begin
    nxt_mask = mask_ff;
    for (int i = 0; i < NCH; i++) begin
      nxt_ctrl[i] = ctrl_ff[i];
      nxt_ctrl[i].channel_on = ch_on[i];
      if (do_wr && wr_ctrl_hit && (wr_idx == i)) begin
        if (ws_ff[1]) begin
          nxt_ctrl[i].chain_direction_select = wd_ff[`DCC_CHAIN_DIR_BIT];
        end
        if (ws_ff[0]) begin
          nxt_ctrl[i].events_while_off = wd_ff[`DCC_EVOFF_BIT];
          nxt_ctrl[i].chain_allow = wd_ff[`DCC_CHAIN_BIT];
          nxt_ctrl[i].auto_reenable = wd_ff[`DCC_AUTO_BIT];
          nxt_ctrl[i].channel_priority_level = wd_ff[`DCC_PRI_HI:`DCC_PRI_LO];
        end
      end
    end
    // Mask takes the merged word so byte strobes apply
    if (do_wr && (awa_ff == `DCC_IRQ_MASK)) begin
      nxt_mask = wmerge[`DCC_IRQ_W-1:0];
    end
    // Read clears status; new events in that cycle still land
    nxt_stat = stat_ff;
    if (do_rd && (ra == `DCC_IRQ_STAT)) begin
      nxt_stat = '0;
    end
    nxt_stat = nxt_stat | {ch_start, eng_block_done};
  end

  // Fixed-priority arbiter, scanned high number first so ties land low
  always_comb begin
    logic [1:0] best;
    logic found;
    best = 2'b00;
    found = 1'b0;
    nxt_grant = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (ch_req[i] && (!found || ctrl_ff[i].channel_priority_level >= best)) begin
        best = ctrl_ff[i].channel_priority_level; // RULE9
        found = 1'b1;
        nxt_grant = 4'(1 << i); // RULE13
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes and read mux
  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
    end
    // Both halves held: perform the write and raise the response
    if (do_wr) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = (wr_ctrl_hit || awa_ff == `DCC_IRQ_MASK || awa_ff == `DCC_IRQ_STAT
        || awa_ff == `DCC_GRANT) ? 2'b00 : 2'b10;
    end else if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    // Read data is captured here and stands until rready
    if (do_rd) begin
      nxt_rv = 1'b1;
      nxt_rr = 2'b00;
      nxt_rd = 32'h0000_0000; // RULE12
      if (rd_ctrl_hit) begin
        nxt_rd[`DCC_ACTIVE_BIT] = ch_active[rd_idx]; // RULE1
        nxt_rd[`DCC_CHAIN_DIR_BIT] = ctrl_ff[rd_idx].chain_direction_select;
        nxt_rd[`DCC_ON_BIT] = ch_on[rd_idx];
        nxt_rd[`DCC_EVOFF_BIT] = ctrl_ff[rd_idx].events_while_off;
        nxt_rd[`DCC_CHAIN_BIT] = ctrl_ff[rd_idx].chain_allow;
        nxt_rd[`DCC_AUTO_BIT] = ctrl_ff[rd_idx].auto_reenable;
        nxt_rd[`DCC_SEEN_BIT] = ch_seen[rd_idx]; // RULE8
        nxt_rd[`DCC_PRI_HI:`DCC_PRI_LO] = ctrl_ff[rd_idx].channel_priority_level;
      end else if (ra == `DCC_IRQ_STAT) begin
        nxt_rd[`DCC_IRQ_W-1:0] = stat_ff;
      end else if (ra == `DCC_IRQ_MASK) begin
        nxt_rd[`DCC_IRQ_W-1:0] = mask_ff;
      end else if (ra == `DCC_GRANT) begin
        nxt_rd[3:0] = grant_ff;
      end else begin
        nxt_rr = 2'b10;
      end
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register control fields, interrupt state and event strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_ff[i] <= '0;
      end
      stat_ff <= '0;
      mask_ff <= '0;
      start_taken_ff <= '0;
      abort_taken_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_ff[i] <= nxt_ctrl[i];
      end
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      start_taken_ff <= ch_start;
      abort_taken_ff <= ch_abort;
      // Built from next values so the line follows status with no extra lag
      irq_ff <= |(nxt_stat & nxt_mask);
    end
  end

  // Register the grant; it trails a request change by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grant_ff <= '0;
    end else begin
      grant_ff <= nxt_grant;
    end
  end

  // Register the bus side, readies included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 8'h00;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bv_ff <= 1'b0;
      br_ff <= 2'b00;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rr_ff <= 2'b00;
      awrdy_ff <= 1'b1;
      wrdy_ff <= 1'b1;
      ardy_ff <= 1'b1;
    end else begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
      // Taken from next state, so each ready matches its slot being free
      awrdy_ff <= !nxt_aw && !nxt_bv;
      wrdy_ff <= !nxt_w && !nxt_bv;
      ardy_ff <= !nxt_rv;
    end
  end

endmodule

// [dcc_monitor.sv]
// Port-level checker for dcc_top, attached by bind.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/1ps
module dcc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [3:0] eng_start,
  input wire logic [3:0] eng_abort,
  input wire logic [3:0] grant_ff,
  input wire logic [3:0] start_taken_ff,
  input wire logic [3:0] abort_taken_ff
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////
  // Accepted events trace back to a strobe one cycle earlier
  a_start_cause: assert property ((start_taken_ff & ~$past(eng_start)) == 4'h0)
    else $error("start accepted without strobe");
  a_abort_cause: assert property ((abort_taken_ff & ~$past(eng_abort)) == 4'h0)
    else $error("abort accepted without strobe");
  // At most one channel owns the bus
  a_grant_onehot: assert property ($onehot0(grant_ff))
    else $error("grant not one-hot");
  // Unimplemented upper half always reads zero
  a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper half not zero");
  a_error_zero: assert property (
    s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
  // Status polling needs a read answer one cycle after the address
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while answering");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  c_grant: cover property (grant_ff != 4'h0);
  c_start: cover property (start_taken_ff != 4'h0);
  c_error: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule
bind dcc_top dcc_monitor mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .eng_start, .eng_abort, .grant_ff, .start_taken_ff, .abort_taken_ff);

// [dcc_eng_model.sv]
// Transfer-engine stand-in: per-channel event strobes and bus-busy level.
// Assumes its tasks are called just after a rising edge of aclk.
`timescale 1ns/1ps
module dcc_eng_model (
  input wire logic aclk,
  output logic [3:0] eng_start,
  output logic [3:0] eng_abort,
  output logic [3:0] eng_block_done,
  output logic [3:0] eng_bus_busy
);
  // Idle strobes from time zero
  initial begin
    eng_start = 4'h0;
    eng_abort = 4'h0;
    eng_block_done = 4'h0;
    eng_bus_busy = 4'h0;
  end
  // One-cycle strobe: 0 start, 1 abort, 2 block done
  task automatic pulse(input int t, input logic [3:0] m);
    if (t == 0) eng_start <= m;
    if (t == 1) eng_abort <= m;
    if (t == 2) eng_block_done <= m;
    @(posedge aclk);
    eng_start <= 4'h0;
    eng_abort <= 4'h0;
    eng_block_done <= 4'h0;
  endtask
  // Level held until changed, so a slow bus beat lasts as long as wanted
  task automatic set_busy(input logic [3:0] m);
    eng_bus_busy <= m;
  endtask
endmodule

// [tb.sv]
// Bench: register bus and engine stimulus checked against a small reference model.
// Assumes the package, design, engine model and checker compile first.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_ff;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, v;
  logic [3:0] eng_start, eng_abort, eng_block_done, eng_bus_busy;
  logic [3:0] grant_ff, start_taken_ff, abort_taken_ff;
  logic [31:0] m_ctl [4];
  logic [3:0] m_seen = 4'h0;
  logic [7:0] m_st = 8'h0;
  logic [7:0] m_mask = 8'h0;
  int n_mismatch = 0;
  int n_checks = 0;
  int i;
  int k;
  ////////////////////
  // 50 ns period
  always #25 aclk = ~aclk;
  // Response ready held high so no answer is ever stalled
  dcc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .eng_start, .eng_abort,
    .eng_block_done, .eng_bus_busy, .grant_ff, .start_taken_ff, .abort_taken_ff, .irq_ff);
  dcc_eng_model eng (.aclk, .eng_start, .eng_abort, .eng_block_done, .eng_bus_busy);
  ////////////////////
  task automatic end_of_test();
    $display("Mismatches %0d of %0d checks", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 99) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 99);
    tmo(n);
    `CHK(s_axi_bresp, e)
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] q);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 99);
    tmo(n);
    d = s_axi_rdata;
    q = s_axi_rresp;
  endtask
  // A control read also clears that channel's event-seen flag
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] q);
    rd(a, v, r);
    `CHK(v, e)
    `CHK(r, q)
    if (a < 8'h10) m_seen[a[3:2]] = 1'b0;
  endtask
  function automatic logic [31:0] ex(input int c);
    return m_ctl[c] | {16'h0, m_ctl[c][7], 12'h0, m_seen[c], 2'b00};
  endfunction
  task automatic setc(input int c, input logic [31:0] d);
    m_ctl[c] = d & 32'h0000_01f3;
    wr(8'(c * 4), d, 2'b00);
  endtask
  // Highest priority wins, lowest channel on a tie
  function automatic logic [3:0] eg();
    int c;
    int b;
    b = -1;
    for (c = 3; c >= 0; c--) begin
      if (m_ctl[c][7] && m_seen[c] && (b < 0 || m_ctl[c][1:0] >= m_ctl[b][1:0])) b = c;
    end
    return (b < 0) ? 4'h0 : 4'(1 << b);
  endfunction
  task automatic settle();
    int n;
    for (n = 0; n < 8 && (grant_ff !== eg() || irq_ff !== |(m_st & m_mask)); n++) begin
      @(posedge aclk);
    end
    `CHK(grant_ff, eg())
    `CHK(irq_ff, |(m_st & m_mask))
  endtask
  // Strobe kinds: 0 start, 1 abort, 2 block done; chain enable wins over auto clear
  task automatic ev(input int t, input logic [3:0] m);
    logic [3:0] tk;
    int c;
    eng.pulse(t, m);
    @(negedge aclk);
    for (c = 0; c < 4; c++) begin
      tk[c] = m[c] & (m_ctl[c][7] | m_ctl[c][6]);
      if (t == 0 && tk[c]) m_seen[c] = 1'b1;
      if (t == 0 && tk[c]) m_st[c + 4] = 1'b1;
      if (t == 1 && tk[c]) m_seen[c] = 1'b0;
      if (t == 1 && tk[c]) m_ctl[c][7] = 1'b0;
      if (t == 2 && m[c]) m_st[c] = 1'b1;
      if (t == 2 && m[c]) m_seen[c] = 1'b0;
      if (t == 2 && m[c] && !m_ctl[c][4]) m_ctl[c][7] = 1'b0;
    end
    for (c = 0; c < 4; c++) begin
      k = m_ctl[c][8] ? c + 1 : c - 1;
      if (t == 2 && m_ctl[c][5] && k >= 0 && k < 4 && m[k]) m_ctl[c][7] = 1'b1;
    end
    `CHK(start_taken_ff, (t == 0) ? tk : 4'h0)
    `CHK(abort_taken_ff, (t == 1) ? tk : 4'h0)
    @(posedge aclk);
  endtask
  ////////////////////
  initial begin
    k = $urandom(36);
    for (i = 0; i < 4; i++) m_ctl[i] = 32'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 4; i++) rdc(8'(i * 4), 32'h0, 2'b00);
    rdc(8'h1c, 32'h0, 2'b10);
    wr(8'h1c, 32'hffff_ffff, 2'b10);
    setc(0, 32'hffff_ffff);
    rdc(8'h00, ex(0), 2'b00);
    // Events on a disabled channel, ignored then accepted
    for (i = 0; i < 2; i++) begin
      setc(1, {25'h0, i[0], 6'h0});
      ev(0, 4'h2);
      rdc(8'h04, ex(1), 2'b00);
      ev(1, 4'h2);
    end
    for (i = 0; i < 2; i++) begin
      setc(2, {27'h0, i[0], 4'h0} | 32'h80);
      ev(2, 4'h4);
      // Active lingers two cycles, one in run and one in drain, after the enable is cleared
      @(posedge aclk);
      rdc(8'h08, ex(2), 2'b00);
    end
    // Every allow and direction setting against both neighbours
    for (i = 0; i < 8; i++) begin
      setc(1, {23'h0, i[1], 2'b00, i[0], 5'h0});
      ev(2, i[2] ? 4'h4 : 4'h1);
      rdc(8'h04, ex(1), 2'b00);
    end
    // Disable during a slow bus beat, then poll until suspended
    setc(3, 32'h80);
    eng.set_busy(4'h8);
    setc(3, 32'h0);
    rdc(8'h0c, 32'h8000, 2'b00);
    eng.set_busy(4'h0);
    for (i = 0; i < 20 && v[15]; i++) rd(8'h0c, v, r);
    `CHK(v, 32'h0)
    wr(8'h14, 32'hff, 2'b00);
    m_mask = 8'hff;
    rdc(8'h10, {24'h0, m_st}, 2'b00);
    m_st = 8'h0;
    settle();
    ev(0, 4'h1);
    settle();
    wr(8'h14, 32'h0f, 2'b00);
    m_mask = 8'h0f;
    settle();
    // Random priorities with all channels running
    for (i = 0; i < 4; i++) setc(i, 32'h90);
    ev(0, 4'hf);
    for (i = 0; i < 16; i++) begin
      setc($urandom % 4, 32'h90 | ($urandom & 3));
      settle();
    end
    rdc(8'h18, {28'h0, eg()}, 2'b00);
    ev(1, 4'hf);
    settle();
    @(posedge aclk); // Let the drain cycle pass before reading active
    for (i = 0; i < 4; i++) rdc(8'(i * 4), ex(i), 2'b00);
    end_of_test();
  end
endmodule
